// >>> pkg/rtcg_defs.svh
// Constants of the clock gateway: offsets, fields, codes and timing.
// Assumes inclusion by bare name from design files.
`ifndef RTCG_DEFS_SVH
`define RTCG_DEFS_SVH
`define RTCG_OFS_ADR 8'hac
`define RTCG_OFS_DAT 8'had
`define RTCG_OFS_KEY 8'hae
`define RTCG_KEY_FIRST 8'ha5
`define RTCG_KEY_SECOND 8'hf1
`define RTCG_CODE_LOCKED 8'h00
`define RTCG_CODE_FIRST 8'h01
`define RTCG_CODE_OPEN 8'h02
`define RTCG_CODE_DISABLED 8'h03
`define RTCG_ADR_BUSY 7
`define RTCG_ADR_AUTO_READ_ENABLE 6
`define RTCG_ADR_VREG 5
`define RTCG_ADR_SHORT 4
`define RTCG_TGT_CAP_LAST 4'h5
`define RTCG_TGT_CTL 4'h6
`define RTCG_TGT_XCN 4'h7
`define RTCG_TGT_ALM_FIRST 4'h8
`define RTCG_TGT_ALM_LAST 4'hd
`define RTCG_TGT_RAMIDX 4'he
`define RTCG_TGT_RAMDAT 4'hf
`define RTCG_CTL_POWER 7
`define RTCG_CTL_MCLK 6
`define RTCG_CTL_FAIL 5
`define RTCG_CTL_RUN 4
`define RTCG_CTL_ALEN 3
`define RTCG_XCN_AGC 7
`define RTCG_XCN_CRYSTAL_MODE_SELECT 6
`define RTCG_XCN_BIAS 5
`define RTCG_XCN_VALID 4
`define RTCG_XCN_VBAT 0
`define RTCG_RESET_BIT 1'h0
`define RTCG_RESET_RAMIDX 6'h00
`define RTCG_STROBE_LONG 3'h4
`define RTCG_STROBE_SHORT 3'h1
`define RTCG_CLK_PERIOD_NS 8
`define RTCG_MCLK_TIMEOUT_US 50
`define RTCG_MCLK_CYCLES \
  ((`RTCG_MCLK_TIMEOUT_US * 1000 + `RTCG_CLK_PERIOD_NS - 1) / `RTCG_CLK_PERIOD_NS)
`define RTCG_RAM_DEPTH 64
`define RTCG_BANK_DEPTH 16
`endif

// >>> pkg/rtcg_pkg.sv
// Types shared by the clock gateway design files.
// Assumes nothing of its surroundings.
package rtcg_pkg;
  typedef enum logic [1:0] {
    LOCK_LOCKED,
    LOCK_FIRST_OK,
    LOCK_OPEN,
    LOCK_DISABLED
  } rtcg_lock_type;
  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_STROBE,
    XFER_FINISH
  } rtcg_xfer_type;
endpackage : rtcg_pkg

// >>> logic/rtcg_byte_mem.sv
// Small byte memory with a registered read port.
// Assumes one clock; contents are not reset.
`timescale 1ns/100ps
`default_nettype none
module rtcg_byte_mem
  import rtcg_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= mem[i_addr];
  end
endmodule : rtcg_byte_mem
`default_nettype wire

// >>> logic/rtcg_clock_watch.sv
// Missing-clock detector: one pulse when the timebase level stalls.
// Assumes i_level is already synchronised to i_clk.
`timescale 1ns/100ps
`default_nettype none
module rtcg_clock_watch
  import rtcg_pkg::*;
#(
  parameter int unsigned LIMIT = 6250,
  parameter int unsigned CW = 13
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  input wire logic i_level,
  output logic o_timeout
);
  localparam logic [CW-1:0] LIM_M1 = CW'(LIMIT - 1);
  logic prev;
  logic [CW-1:0] count;
  logic stalled;

  assign stalled = i_enable && (i_level == prev);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev <= 1'h0;
    end else begin
      prev <= i_level;
    end
  end

  // The count saturates at the limit, one past the firing value, so a stall fires only once.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count <= '0;
      o_timeout <= 1'h0;
    end else begin
      o_timeout <= stalled && (count == LIM_M1);
      if (!stalled) begin
        count <= '0;
      end else if (count <= LIM_M1) begin
        count <= count + 1'h1;
      end
    end
  end
endmodule : rtcg_clock_watch
`default_nettype wire

// >>> logic/rtcg_rtc_gateway.sv
// Clock gateway: lock and key, indirect access, oscillator control.
// Assumes a one-access-per-cycle register port on i_clk.
//
// Summary of operation
// - Key register reads return lock state code.
// - First then second key unlocks interface.
// - Wrong second key disables until reset.
// - Any key write while unlocked relocks.
// - Key writes ignored while disabled.
// - Setting busy starts read; hardware clears it.
// - Busy reads one during any transfer.
// - Auto read: data read starts next read.
// - Backup force sets itself; write forces backup.
// - Strobe four clocks, or one when short.
// - Target select decodes sixteen internal registers.
// - Target increments after snapshot or match access.
// - Data register holds byte; write starts transfer.
// - Clock core runs from its own timebase.
// - Self oscillation: bias double picks frequency.
// - Stalled timebase over limit sets fail flag.
// - Timeout wakes, interrupts, resets as enabled.
// - Bad key or access disables until reset.
// - Address and data registers survive reset, except backup force and busy.
// - Fail flag sticky until software clears.
`timescale 1ns/100ps
`default_nettype none
`include "rtcg_defs.svh"
module rtcg_rtc_gateway
  import rtcg_pkg::*;
#(
  parameter int unsigned MCLK_LIMIT = `RTCG_MCLK_CYCLES,
  parameter int unsigned MCLK_CW = 13
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_rtc_timebase,
  input wire logic i_backup_above_core,
  input wire logic i_crystal_stable,
  input wire logic i_on_backup,
  input wire logic i_clock_irq_enable,
  input wire logic i_reset_source_enable,
  output logic o_strobe,
  output logic o_osc_power,
  output logic o_crystal_mode,
  output logic o_auto_gain,
  output logic o_bias_double,
  output logic o_backup_force,
  output logic o_wake,
  output logic o_clock_irq,
  output logic o_reset_request
);
  // ****************************************************************
  // Register port decode
  // ****************************************************************
  rtcg_lock_type lock;
  rtcg_xfer_type xfer;
  logic [7:0] lock_code;
  logic wr_key, wr_adr, wr_dat, rd_key, rd_adr, rd_dat;
  logic acc_any, acc_bad;
  logic start_rd, start_wr, fin_wr, fin_rd;
  logic busy, auto_read, short_access, short_now;
  logic [3:0] target;
  logic [2:0] cnt;
  logic op_write;
  logic [7:0] data_reg, rd_value, bank_q, ram_q;
  logic is_bank;
  logic mclk_en, fail_flag, timer_run, alarm_en;
  logic [5:0] ram_index;
  logic tb_meta, tb_sync, mclk_timeout;

  assign wr_key = i_sfr_wr && (i_sfr_addr == `RTCG_OFS_KEY);
  assign wr_adr = i_sfr_wr && (i_sfr_addr == `RTCG_OFS_ADR);
  assign wr_dat = i_sfr_wr && (i_sfr_addr == `RTCG_OFS_DAT);
  assign rd_key = i_sfr_rd && (i_sfr_addr == `RTCG_OFS_KEY);
  assign rd_adr = i_sfr_rd && (i_sfr_addr == `RTCG_OFS_ADR);
  assign rd_dat = i_sfr_rd && (i_sfr_addr == `RTCG_OFS_DAT);
  assign acc_any = wr_adr || wr_dat || rd_adr || rd_dat;
  // Of address and data accesses, only polling the address register is legal while a transfer runs.
  assign acc_bad = acc_any && ((lock != LOCK_OPEN) || (busy && !rd_adr));
  assign start_rd = !acc_bad && ((wr_adr && i_sfr_wdata[`RTCG_ADR_BUSY]) ||
                    (rd_dat && auto_read));
  assign start_wr = !acc_bad && wr_dat;
  assign fin_wr = (xfer == XFER_FINISH) && op_write;
  assign fin_rd = (xfer == XFER_FINISH) && !op_write;
  // A read started by an address write takes the short bit written with it.
  assign short_now = wr_adr ? i_sfr_wdata[`RTCG_ADR_SHORT] : short_access;
  assign is_bank = (target <= `RTCG_TGT_CAP_LAST) ||
                   ((target >= `RTCG_TGT_ALM_FIRST) && (target <= `RTCG_TGT_ALM_LAST));

  // ****************************************************************
  // Lock and key
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock <= LOCK_LOCKED;
    end else if (acc_bad) begin
      lock <= LOCK_DISABLED;
    end else if (wr_key) begin
      unique case (lock)
        LOCK_LOCKED: begin
          lock <= (i_sfr_wdata == `RTCG_KEY_FIRST) ? LOCK_FIRST_OK : LOCK_DISABLED;
        end
        LOCK_FIRST_OK: begin
          lock <= (i_sfr_wdata == `RTCG_KEY_SECOND) ? LOCK_OPEN : LOCK_DISABLED;
        end
        LOCK_OPEN: begin
          lock <= LOCK_LOCKED;
        end
        LOCK_DISABLED: begin
          lock <= LOCK_DISABLED;
        end
      endcase
    end
  end

  always_comb begin
    unique case (lock)
      LOCK_LOCKED: lock_code = `RTCG_CODE_LOCKED;
      LOCK_FIRST_OK: lock_code = `RTCG_CODE_FIRST;
      LOCK_OPEN: lock_code = `RTCG_CODE_OPEN;
      LOCK_DISABLED: lock_code = `RTCG_CODE_DISABLED;
    endcase
  end

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  // The strobe is the handoff to the timebase-side core; busy stays up
  // through one settling cycle after the strobe ends.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      xfer <= XFER_IDLE;
      cnt <= 3'h0;
      op_write <= 1'h0;
      busy <= 1'h0;
      o_strobe <= 1'h0;
    end else begin
      unique case (xfer)
        XFER_IDLE: begin
          if (start_rd || start_wr) begin
            xfer <= XFER_STROBE;
            cnt <= (short_now ? `RTCG_STROBE_SHORT : `RTCG_STROBE_LONG) - 3'h1;
            op_write <= start_wr;
            busy <= 1'h1;
            o_strobe <= 1'h1;
          end
        end
        XFER_STROBE: begin
          if (cnt == 3'h0) begin
            xfer <= XFER_FINISH;
            o_strobe <= 1'h0;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        XFER_FINISH: begin
          xfer <= XFER_IDLE;
          busy <= 1'h0;
        end
        default: begin
          xfer <= XFER_IDLE;
          busy <= 1'h0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Address and data registers
  // ****************************************************************
  // No reset here: these fields keep their contents through reset.
  always_ff @(posedge i_clk) begin
    if (wr_adr && !acc_bad) begin
      auto_read <= i_sfr_wdata[`RTCG_ADR_AUTO_READ_ENABLE];
      short_access <= i_sfr_wdata[`RTCG_ADR_SHORT];
      target <= i_sfr_wdata[3:0];
    end else if ((xfer == XFER_FINISH) && is_bank) begin
      target <= target + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (start_wr) begin
      data_reg <= i_sfr_wdata;
    end else if (fin_rd) begin
      data_reg <= rd_value;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_backup_force <= `RTCG_RESET_BIT;
    end else if (i_backup_above_core) begin
      o_backup_force <= 1'h1;
    end else if (wr_adr && !acc_bad) begin
      o_backup_force <= i_sfr_wdata[`RTCG_ADR_VREG];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (rd_key) begin
      o_sfr_rdata <= lock_code;
    end else if (rd_adr && !acc_bad) begin
      o_sfr_rdata <= {busy, auto_read, o_backup_force, short_access, target};
    end else if (rd_dat && !acc_bad) begin
      o_sfr_rdata <= data_reg;
    end else begin
      o_sfr_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // Internal registers
  // ****************************************************************
  rtcg_byte_mem #(
    .DEPTH(`RTCG_BANK_DEPTH),
    .AW(4)
  ) u_bank (
    .i_clk(i_clk),
    .i_we(fin_wr && is_bank),
    .i_addr(target),
    .i_wdata(data_reg),
    .o_rdata(bank_q)
  );

  rtcg_byte_mem #(
    .DEPTH(`RTCG_RAM_DEPTH),
    .AW(6)
  ) u_ram (
    .i_clk(i_clk),
    .i_we(fin_wr && (target == `RTCG_TGT_RAMDAT)),
    .i_addr(ram_index),
    .i_wdata(data_reg),
    .o_rdata(ram_q)
  );

  always_comb begin
    rd_value = 8'h00;
    if (is_bank) begin
      rd_value = bank_q;
    end else if (target == `RTCG_TGT_CTL) begin
      rd_value = {o_osc_power, mclk_en, fail_flag, timer_run, alarm_en, 3'h0};
    end else if (target == `RTCG_TGT_XCN) begin
      rd_value = {o_auto_gain, o_crystal_mode, o_bias_double,
                  !o_crystal_mode || i_crystal_stable, 3'h0,
                  !o_osc_power || i_on_backup};
    end else if (target == `RTCG_TGT_RAMIDX) begin
      rd_value = {2'h0, ram_index};
    end else begin
      rd_value = ram_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_osc_power <= `RTCG_RESET_BIT;
      mclk_en <= `RTCG_RESET_BIT;
      timer_run <= `RTCG_RESET_BIT;
      alarm_en <= `RTCG_RESET_BIT;
      o_auto_gain <= `RTCG_RESET_BIT;
      o_crystal_mode <= `RTCG_RESET_BIT;
      o_bias_double <= `RTCG_RESET_BIT;
      ram_index <= `RTCG_RESET_RAMIDX;
    end else if (fin_wr) begin
      if (target == `RTCG_TGT_CTL) begin
        o_osc_power <= data_reg[`RTCG_CTL_POWER];
        mclk_en <= data_reg[`RTCG_CTL_MCLK];
        timer_run <= data_reg[`RTCG_CTL_RUN];
        alarm_en <= data_reg[`RTCG_CTL_ALEN];
      end
      if (target == `RTCG_TGT_XCN) begin
        o_auto_gain <= data_reg[`RTCG_XCN_AGC];
        o_crystal_mode <= data_reg[`RTCG_XCN_CRYSTAL_MODE_SELECT];
        o_bias_double <= data_reg[`RTCG_XCN_BIAS];
      end
      if (target == `RTCG_TGT_RAMIDX) begin
        ram_index <= data_reg[5:0];
      end
    end
  end

  // ****************************************************************
  // Missing-clock detector
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tb_meta <= 1'h0;
      tb_sync <= 1'h0;
    end else begin
      tb_meta <= i_rtc_timebase;
      tb_sync <= tb_meta;
    end
  end

  rtcg_clock_watch #(
    .LIMIT(MCLK_LIMIT),
    .CW(MCLK_CW)
  ) u_watch (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_enable(mclk_en),
    .i_level(tb_sync),
    .o_timeout(mclk_timeout)
  );

  // A timeout in the same cycle as a software clear wins.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fail_flag <= `RTCG_RESET_BIT;
    end else if (mclk_timeout) begin
      fail_flag <= 1'h1;
    end else if (fin_wr && (target == `RTCG_TGT_CTL)) begin
      fail_flag <= data_reg[`RTCG_CTL_FAIL];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wake <= 1'h0;
      o_clock_irq <= 1'h0;
      o_reset_request <= 1'h0;
    end else begin
      o_wake <= mclk_timeout;
      o_clock_irq <= mclk_timeout && i_clock_irq_enable;
      o_reset_request <= mclk_timeout && i_reset_source_enable;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_key1;
    wr_key && (lock == LOCK_LOCKED) && (i_sfr_wdata == 8'ha5);
  endsequence
  sequence s_key2;
    wr_key && (lock == LOCK_FIRST_OK) && (i_sfr_wdata == 8'hf1);
  endsequence
  sequence s_long;
    (xfer == XFER_IDLE) && (start_rd || start_wr) && !short_now;
  endsequence
  sequence s_short;
    (xfer == XFER_IDLE) && (start_rd || start_wr) && short_now;
  endsequence

  key_read_code_a: assert property ((rd_key && lock == LOCK_OPEN) |=> o_sfr_rdata == 8'h02)
    else $error("key read code wrong");
  unlock_seq_a: assert property (s_key1 ##[1:8] s_key2 |=> lock == LOCK_OPEN)
    else $error("key sequence did not unlock");
  bad_second_a: assert property ((wr_key && lock == LOCK_FIRST_OK && i_sfr_wdata != 8'hf1)
    |=> (lock == LOCK_DISABLED)[*2])
    else $error("wrong second key not disabling");
  relock_a: assert property ((wr_key && lock == LOCK_OPEN && !acc_bad)
    |=> lock == LOCK_LOCKED)
    else $error("unlocked key write did not relock");
  disabled_hold_a: assert property (lock == LOCK_DISABLED |=> lock == LOCK_DISABLED)
    else $error("disabled state left");
  bad_access_a: assert property ((acc_any && lock != LOCK_OPEN) |=> lock == LOCK_DISABLED)
    else $error("invalid access not disabling");
  read_done_a: assert property (start_rd |=> busy ##[1:5] !busy)
    else $error("busy not cleared after read");
  long_strobe_a: assert property (s_long |=> (busy && o_strobe)[*4] ##1 busy ##1 !busy)
    else $error("long strobe width wrong");
  short_strobe_a: assert property (s_short |=> o_strobe ##1 (busy && !o_strobe) ##1 !busy)
    else $error("short strobe width wrong");
  busy_state_a: assert property (busy == (xfer != XFER_IDLE))
    else $error("busy disagrees with transfer");
  auto_read_a: assert property ((rd_dat && !acc_bad && auto_read) |=> busy && !op_write)
    else $error("auto read not started");
  auto_inc_a: assert property ((xfer == XFER_FINISH && is_bank)
    |=> target == $past(target) + 4'h1)
    else $error("target not incremented");
  fail_sticky_a: assert property ((fail_flag && !(fin_wr && target == `RTCG_TGT_CTL))
    |=> fail_flag)
    else $error("fail flag dropped by hardware");
  timeout_events_a: assert property (mclk_timeout |=> o_wake && fail_flag)
    else $error("timeout did not wake and flag");
  force_set_a: assert property (i_backup_above_core |=> o_backup_force)
    else $error("backup force not set");
endmodule : rtcg_rtc_gateway
`default_nettype wire

// >>> tb/rtcg_host_model.sv
// Host model: the processor side of the gateway register port.
// Assumes the bench calls its tasks only after reset is released.
`timescale 1ns/100ps
`default_nettype none
`include "rtcg_defs.svh"
module rtcg_host_model
  import rtcg_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  // ****************************************
  // Register cycles
  // ****************************************
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // Every write is a plain write; the data register is never read back first.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : rd
  // Busy is polled until clear, under a bound; the bench calls it after each put write and before each get read.
  task automatic idle(output bit ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++) begin
      rd(`RTCG_OFS_ADR, v);
      ok = (v[7] === 1'b0);
    end
  endtask : idle
  task automatic unlock;
    wr(`RTCG_OFS_KEY, `RTCG_KEY_FIRST);
    wr(`RTCG_OFS_KEY, `RTCG_KEY_SECOND);
  endtask : unlock
endmodule : rtcg_host_model
`default_nettype wire

// >>> tb/rtcg_rtc_gateway_bench.sv
// Bench of the clock gateway: key, indirect access, oscillator, detector.
// Assumes the design files and the host model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "rtcg_defs.svh"
module rtcg_rtc_gateway_bench
  import rtcg_pkg::*;
;
  localparam logic [7:0] ADR = `RTCG_OFS_ADR;
  localparam logic [7:0] DAT = `RTCG_OFS_DAT;
  localparam logic [7:0] KEY = `RTCG_OFS_KEY;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, strobe, power, crystal_mode_select, agc, bias, force_o, wake, irq, rst_req;
  logic above = 1'b0, stable = 1'b0, on_bat = 1'b0, irq_en = 1'b0, rst_en = 1'b0;
  logic tb_run = 1'b1;
  logic [2:0] tb_cnt = 3'h0;
  int cycles = 0, strobes = 0, wakes = 0, irqs = 0, rsts = 0;
  int miscompares = 0, check_count = 0;
  logic [31:0] seed = 32'hdbb687b7;
  logic [7:0] bank [16];
  // ****************************************
  // Clock, timebase, design and host
  // ****************************************
  always #4 i_clk = ~i_clk;
  // The timebase toggles every four cycles and stands still when stalled.
  always @(posedge i_clk) begin
    if (tb_run) tb_cnt <= tb_cnt + 3'h1;
    cycles <= cycles + 1;
    if (strobe === 1'b1) strobes <= strobes + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (rst_req === 1'b1) rsts <= rsts + 1;
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  rtcg_rtc_gateway #(.MCLK_LIMIT(20), .MCLK_CW(13)) i_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_rtc_timebase(tb_cnt[2]), .i_backup_above_core(above),
    .i_crystal_stable(stable), .i_on_backup(on_bat), .i_clock_irq_enable(irq_en),
    .i_reset_source_enable(rst_en), .o_strobe(strobe), .o_osc_power(power),
    .o_crystal_mode(crystal_mode_select), .o_auto_gain(agc), .o_bias_double(bias),
    .o_backup_force(force_o), .o_wake(wake), .o_clock_irq(irq),
    .o_reset_request(rst_req));
  rtcg_host_model i_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdata));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Oscillator read-back with the oscillator powered.
  function automatic logic [7:0] osc_exp(input logic [7:0] w);
    return {w[7:5], ~w[6] | stable, 3'h0, on_bat};
  endfunction : osc_exp
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  task automatic rk(input logic [7:0] exp);
    logic [7:0] v;
    i_host.rd(KEY, v);
    check("key state", v, exp);
  endtask : rk
  task automatic settle;
    bit ok;
    i_host.idle(ok);
    check("idle", 8'(ok), 8'h01);
  endtask : settle
  task automatic put(input logic [7:0] d);
    logic [7:0] v;
    i_host.wr(DAT, d);
    i_host.rd(ADR, v);
    check("busy", 8'(v[7]), 8'h01);
    settle();
  endtask : put
  task automatic get(output logic [7:0] d);
    settle();
    i_host.rd(DAT, d);
  endtask : get
  task automatic rst;
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
  endtask : rst
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] v;
    int s0, w0, q0, r0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rk(8'h00);
    i_host.wr(KEY, 8'ha5);
    rk(8'h01);
    i_host.wr(KEY, 8'hf1);
    rk(8'h02);
    done("key");
    for (int b = 0; b < 2; b++) begin
      i_host.wr(ADR, b ? 8'h18 : 8'h00);
      for (int i = 0; i < 6; i++) begin
        seed = lfsr(seed);
        bank[b * 8 + i] = seed[7:0];
        s0 = strobes;
        put(seed[7:0]);
        check("strobe", 8'(strobes - s0), b ? 8'h01 : 8'h04);
      end
      i_host.rd(ADR, v);
      check("target", v, b ? 8'h1e : 8'h06);
    end
    i_host.wr(ADR, 8'hc0);
    for (int i = 0; i < 6; i++) begin
      get(v);
      check("auto read", v, bank[i]);
    end
    for (int i = 8; i < 14; i++) begin
      settle();
      s0 = strobes;
      i_host.wr(ADR, 8'h90 | 8'(i));
      get(v);
      check("read", v, bank[i]);
      check("read strobe", 8'(strobes - s0), 8'h01);
      i_host.rd(ADR, v);
      check("no auto", 8'(v[7]), 8'h00);
    end
    done("bank");
    @(posedge i_clk);
    stable <= seed[8];
    on_bat <= seed[9];
    i_host.wr(ADR, 8'h07);
    put(8'he0);
    i_host.wr(ADR, 8'h06);
    put(8'h80);
    check("osc pins", 8'({power, crystal_mode_select, agc, bias}), 8'h0f);
    i_host.wr(ADR, 8'h87);
    get(v);
    check("crystal", v, osc_exp(8'he0));
    i_host.wr(ADR, 8'h07);
    put(8'h20);
    i_host.wr(ADR, 8'h87);
    get(v);
    check("self osc", v, osc_exp(8'h20));
    check("self pins", 8'({crystal_mode_select, agc, bias}), 8'h01);
    done("oscillator");
    i_host.wr(ADR, 8'h06);
    put(8'hc0);
    for (int k = 0; k < 2; k++) begin
      w0 = wakes;
      q0 = irqs;
      r0 = rsts;
      @(posedge i_clk);
      irq_en <= k[0];
      rst_en <= ~k[0];
      repeat (40) @(posedge i_clk);
      tb_run <= 1'b0;
      repeat (40) @(posedge i_clk);
      tb_run <= 1'b1;
      check("wake", 8'(wakes - w0), 8'h01);
      check("irq", 8'(irqs - q0), 8'(k));
      check("reset req", 8'(rsts - r0), 8'(1 - k));
      repeat (20) @(posedge i_clk);
      i_host.wr(ADR, 8'h86);
      get(v);
      check("fail flag", v, 8'he0);
      i_host.wr(ADR, 8'h06);
      put(8'hc0);
    end
    done("missing clock");
    seed = lfsr(seed);
    i_host.wr(ADR, 8'h0e);
    put({2'h0, seed[5:0]});
    i_host.wr(ADR, 8'h0f);
    put(seed[15:8]);
    i_host.wr(ADR, 8'h8e);
    get(v);
    check("ram index", v, {2'h0, seed[5:0]});
    i_host.wr(ADR, 8'h8f);
    get(v);
    check("ram data", v, seed[15:8]);
    done("ram");
    @(posedge i_clk);
    above <= 1'b1;
    repeat (4) @(posedge i_clk);
    check("force set", 8'(force_o), 8'h01);
    above <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_host.wr(ADR, 8'h1b);
    #1;
    check("force clear", 8'(force_o), 8'h00);
    i_host.wr(ADR, 8'h3b);
    #1;
    check("force write", 8'(force_o), 8'h01);
    i_host.wr(ADR, 8'h1b);
    done("backup");
    i_host.wr(KEY, 8'h5a);
    rk(8'h00);
    i_host.rd(DAT, v);
    check("refused", v, 8'h00);
    rk(8'h03);
    i_host.wr(KEY, 8'ha5);
    rk(8'h03);
    rst();
    rk(8'h00);
    i_host.unlock();
    i_host.rd(ADR, v);
    check("adr kept", v, 8'h1b);
    i_host.rd(DAT, v);
    check("dat kept", v, seed[15:8]);
    rst();
    i_host.wr(KEY, 8'ha5);
    i_host.wr(KEY, 8'h11);
    rk(8'h03);
    i_host.unlock();
    rk(8'h03);
    done("lock");
    close_out();
  end
endmodule : rtcg_rtc_gateway_bench
`default_nettype wire
